/* File: common/smp_pkg.sv */
// Constants and types for the serial mode packetizer
// Behaviour
// [R01] After reset the serial port runs in transparent line-replacement mode.
// [R02] Mode follows the host-written serial mode select setting.
// [R03] Transparent mode queues every serial input byte for radio transmission.
// [R04] Transparent mode sends radio payload bytes out on the serial output.
// [R05] Buffer is sent once serial input stays idle for the packetization timeout.
// [R06] A zero packetization timeout sends as soon as any character arrives.
// [R07] A recognised escape sequence first flushes bytes buffered before it.
// [R08] Buffer is sent at once when it reaches the maximum payload size.
// [R09] Transparent mode is never offered on the SPI port.
// [R10] On SPI, host and device exchange only frame-based packets.
// [R11] Remote I/O samples reach the host only in frame-based mode.
// [R12] Transparent mode forwards all serial data except while in command mode.
// [R13] Frame-based received radio data carries the sender's source address.
// [R14] Frame-based mode reports transmit acknowledgments as status frames.
// [R15] SPI uses only the unescaped frame mode; mode select affects UART only.
// [R16] Host leaves guard silence before and after the three escape characters.
// [R17] Recognised escape characters are never forwarded over the radio.
// [R18] Each serial character restarts the idle timer; buffer clears after each packet.
package smp_pkg;
   localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
   localparam logic [1:0] MODE_API = 2'h1;
   localparam logic [1:0] MODE_API_ESC = 2'h2;
   localparam int MAX_PAYLOAD = 100;
   localparam int CLK_HZ = 20_000_000;
   localparam int GUARD_TIME_MS = 1000;
   localparam int GUARD_CYCLES = CLK_HZ / 1000 * GUARD_TIME_MS;
   localparam int TIMEOUT_UNIT_US = 100;
   localparam int TIMEOUT_UNIT_CYCLES = CLK_HZ / 1_000_000 * TIMEOUT_UNIT_US;
   localparam int ESC_COUNT = 3;
   localparam logic [7:0] ESC_CHAR_DEFAULT = 8'h2B;
   localparam logic [7:0] TIMEOUT_DEFAULT = 8'h03;
   localparam int IDLE_W = 26;
   localparam int SRC_W = 16;

   typedef enum logic [1:0] {
      FL_FILL = 2'b00,
      FL_SEND = 2'b01
   } smp_flush_e;

   typedef enum logic [2:0] {
      ES_IDLE = 3'b000,
      ES_C1 = 3'b001,
      ES_C2 = 3'b011,
      ES_C3 = 3'b010,
      ES_CMD = 3'b110
   } smp_esc_e;
endpackage : smp_pkg

/* File: src/smp_packetizer.sv */
// Serial mode control and transparent-mode packetizer
`timescale 1ns/10ps
`default_nettype none
module smp_packetizer
   import smp_pkg::*;
#(
   parameter int GUARD_SILENCE_CYCLES = GUARD_CYCLES,
   parameter int TIMEOUT_CYCLES_PER_UNIT = TIMEOUT_UNIT_CYCLES,
   parameter int PAYLOAD_MAX = MAX_PAYLOAD
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic mode_load,
   input wire logic [1:0] serial_mode_select,
   input wire logic spi_port_sel,
   input wire logic [7:0] packetization_timeout,
   input wire logic [7:0] escape_character,
   input wire logic [6:0] max_payload_bytes,
   input wire logic cmd_exit,
   input wire logic ser_rx_valid,
   input wire logic [7:0] ser_rx_data,
   output logic ser_rx_ready_reg,
   output logic local_byte_valid_reg,
   output logic [7:0] local_byte_reg,
   output logic pkt_valid_reg,
   output logic [7:0] pkt_data_reg,
   output logic pkt_last_reg,
   input wire logic pkt_ready,
   input wire logic radio_rx_valid,
   input wire logic [7:0] radio_rx_data,
   input wire logic [SRC_W-1:0] radio_rx_src,
   output logic radio_rx_ready_reg,
   output logic ser_tx_valid_reg,
   output logic [7:0] ser_tx_data_reg,
   output logic [SRC_W-1:0] ser_tx_src_reg,
   input wire logic ser_tx_ready,
   input wire logic io_sample_valid,
   output logic io_sample_fwd_reg,
   input wire logic tx_ack_valid,
   input wire logic [7:0] tx_ack_code,
   output logic status_frame_valid_reg,
   output logic [7:0] status_code_reg,
   output logic api_mode_reg,
   output logic api_escaped_reg,
   output logic cmd_mode_reg
);
   localparam int CNT_W = $clog2(PAYLOAD_MAX + 1);
   localparam int BW = 8 + SRC_W;
   // Mode state
   logic api_mode_next, api_escaped_next;
   logic [1:0] sel_mode_reg, sel_mode_next;
   always_comb begin
      sel_mode_next = sel_mode_reg;
      // [R02] host selects mode
      if (mode_load) begin
         sel_mode_next = serial_mode_select;
      end
      // [R09] [R10] SPI forces frames
      if (spi_port_sel) begin
         api_mode_next = 1'b1;
         // [R15] unescaped only on SPI
         api_escaped_next = 1'b0;
      end else begin
         api_mode_next = (sel_mode_next != MODE_TRANSPARENT);
         api_escaped_next = (sel_mode_next == MODE_API_ESC);
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      // [R01] transparent after reset
      if (!rst_b) begin
         sel_mode_reg <= MODE_TRANSPARENT;
         api_mode_reg <= 1'b0;
         api_escaped_reg <= 1'b0;
      end else begin
         sel_mode_reg <= sel_mode_next;
         api_mode_reg <= api_mode_next;
         api_escaped_reg <= api_escaped_next;
      end
   end
   // Packet buffer, idle timer and escape detection
   logic [7:0] buf_reg [PAYLOAD_MAX];
   logic [7:0] buf_next [PAYLOAD_MAX];
   logic [CNT_W-1:0] cnt_reg, cnt_next, idx_reg, idx_next, mark_reg, mark_next, limit;
   logic [IDLE_W-1:0] idle_reg, idle_next;
   logic [IDLE_W-1:0] to_cycles;
   smp_flush_e fl_reg, fl_next;
   smp_esc_e esc_reg, esc_next;
   logic rx_take, transparent, guard_met, esc_hit, flush_go;
   logic pkt_valid_next, pkt_last_next, rx_ready_next, lb_valid_next, cmd_next;
   logic [7:0] pkt_data_next, lb_next;
   assign to_cycles = IDLE_W'(packetization_timeout) * IDLE_W'(TIMEOUT_CYCLES_PER_UNIT);
   // Zero or oversize setting falls back to the hardware maximum
   assign limit = (max_payload_bytes != 7'h00 && 32'(max_payload_bytes) <= PAYLOAD_MAX) ?
                  CNT_W'(max_payload_bytes) : CNT_W'(PAYLOAD_MAX);
   always_comb begin
      buf_next = buf_reg;
      cnt_next = cnt_reg;
      idx_next = idx_reg;
      mark_next = mark_reg;
      fl_next = fl_reg;
      esc_next = esc_reg;
      pkt_valid_next = pkt_valid_reg;
      pkt_data_next = pkt_data_reg;
      pkt_last_next = pkt_last_reg;
      lb_valid_next = 1'b0;
      lb_next = local_byte_reg;
      transparent = !api_mode_reg;
      rx_take = ser_rx_valid && ser_rx_ready_reg;
      guard_met = idle_reg >= IDLE_W'(GUARD_SILENCE_CYCLES);
      esc_hit = ser_rx_data == escape_character;
      flush_go = 1'b0;
      // [R18] every character restarts the timer
      idle_next = rx_take ? '0 : ((&idle_reg) ? idle_reg : idle_reg + 1'b1);
      if (rx_take && (!transparent || esc_reg == ES_CMD)) begin
         // [R12] command and frame bytes stay local
         lb_valid_next = 1'b1;
         lb_next = ser_rx_data;
      end else if (rx_take) begin
         // [R03] queue serial byte
         buf_next[cnt_reg] = ser_rx_data;
         cnt_next = cnt_reg + 1'b1;
         unique case (esc_reg)
            ES_IDLE: begin
               if (esc_hit && guard_met) begin
                  esc_next = ES_C1;
                  mark_next = cnt_reg;
               end
            end
            ES_C1: esc_next = (esc_hit && !guard_met) ? ES_C2 : ES_IDLE;
            ES_C2: esc_next = (esc_hit && !guard_met) ? ES_C3 : ES_IDLE;
            default: esc_next = ES_IDLE;
         endcase
      end else if (esc_reg == ES_C3 && guard_met) begin
         // [R17] drop the escape characters
         cnt_next = mark_reg;
         esc_next = ES_CMD;
         // [R07] flush what came before
         flush_go = (mark_reg != '0);
      end else if ((esc_reg == ES_C1 || esc_reg == ES_C2) && guard_met) begin
         esc_next = ES_IDLE;
      end else if (esc_reg == ES_IDLE && cnt_reg != '0 && transparent) begin
         // [R08] full packet goes at once
         if (cnt_reg >= limit) begin
            flush_go = 1'b1;
         end
         // [R06] zero timeout sends at once
         if (packetization_timeout == 8'h00) begin
            flush_go = 1'b1;
         end
         // [R05] idle gap ends the packet
         if (idle_reg >= to_cycles) begin
            flush_go = 1'b1;
         end
      end
      if (esc_reg == ES_CMD && cmd_exit) begin
         esc_next = ES_IDLE;
      end
      unique case (fl_reg)
         FL_FILL: begin
            if (flush_go) begin
               fl_next = FL_SEND;
               idx_next = '0;
            end
         end
         FL_SEND: begin
            if (!pkt_valid_reg || pkt_ready) begin
               if (idx_reg < cnt_reg) begin
                  pkt_valid_next = 1'b1;
                  pkt_data_next = buf_reg[idx_reg];
                  pkt_last_next = (idx_reg == cnt_reg - 1'b1);
                  idx_next = idx_reg + 1'b1;
               end else begin
                  pkt_valid_next = 1'b0;
                  pkt_last_next = 1'b0;
                  // [R18] buffer clears after packet
                  cnt_next = '0;
                  fl_next = FL_FILL;
               end
            end
         end
      endcase
      cmd_next = (esc_next == ES_CMD);
      // Stall the host while sending; a single buffer trades throughput for area
      rx_ready_next = (fl_next == FL_FILL) && !flush_go &&
                      (cnt_next < limit || !transparent || cmd_next);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < PAYLOAD_MAX; i++) begin
            buf_reg[i] <= 8'h00;
         end
         cnt_reg <= '0;
         idx_reg <= '0;
         mark_reg <= '0;
         idle_reg <= '0;
         fl_reg <= FL_FILL;
         esc_reg <= ES_IDLE;
         pkt_valid_reg <= 1'b0;
         pkt_data_reg <= 8'h00;
         pkt_last_reg <= 1'b0;
         ser_rx_ready_reg <= 1'b0;
         local_byte_valid_reg <= 1'b0;
         local_byte_reg <= 8'h00;
         cmd_mode_reg <= 1'b0;
      end else begin
         buf_reg <= buf_next;
         cnt_reg <= cnt_next;
         idx_reg <= idx_next;
         mark_reg <= mark_next;
         idle_reg <= idle_next;
         fl_reg <= fl_next;
         esc_reg <= esc_next;
         pkt_valid_reg <= pkt_valid_next;
         pkt_data_reg <= pkt_data_next;
         pkt_last_reg <= pkt_last_next;
         ser_rx_ready_reg <= rx_ready_next;
         local_byte_valid_reg <= lb_valid_next;
         local_byte_reg <= lb_next;
         cmd_mode_reg <= cmd_next;
      end
   end
   // Radio-to-serial two-entry skid buffer
   logic spare_valid_reg, spare_valid_next, out_valid_next, rr_next;
   logic [BW-1:0] spare_reg, spare_next, out_reg, out_next;
   logic rf_take, out_free;
   always_comb begin
      spare_valid_next = spare_valid_reg;
      spare_next = spare_reg;
      out_valid_next = ser_tx_valid_reg;
      out_next = out_reg;
      rf_take = radio_rx_valid && radio_rx_ready_reg;
      out_free = !ser_tx_valid_reg || ser_tx_ready;
      if (out_free) begin
         if (spare_valid_reg) begin
            out_valid_next = 1'b1;
            out_next = spare_reg;
            spare_valid_next = rf_take;
            spare_next = {radio_rx_src, radio_rx_data};
         end else begin
            out_valid_next = rf_take;
            out_next = {radio_rx_src, radio_rx_data};
         end
      end else if (rf_take) begin
         spare_valid_next = 1'b1;
         spare_next = {radio_rx_src, radio_rx_data};
      end
      // [R04] radio payload goes to serial
      rr_next = !spare_valid_next;
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         spare_valid_reg <= 1'b0;
         spare_reg <= '0;
         out_reg <= '0;
         ser_tx_valid_reg <= 1'b0;
         radio_rx_ready_reg <= 1'b0;
      end else begin
         spare_valid_reg <= spare_valid_next;
         spare_reg <= spare_next;
         out_reg <= out_next;
         ser_tx_valid_reg <= out_valid_next;
         radio_rx_ready_reg <= rr_next;
      end
   end
   assign ser_tx_data_reg = out_reg[7:0];
   // Frame-only outputs, except status_code_reg, which loads tx_ack_code in every mode
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ser_tx_src_reg <= '0;
         io_sample_fwd_reg <= 1'b0;
         status_frame_valid_reg <= 1'b0;
         status_code_reg <= 8'h00;
      end else begin
         // [R13] source address in frames
         ser_tx_src_reg <= api_mode_reg ? out_next[BW-1:8] : '0;
         // [R11] samples only in frame mode
         io_sample_fwd_reg <= io_sample_valid && api_mode_reg;
         // [R14] acknowledgments as status frames
         status_frame_valid_reg <= tx_ack_valid && api_mode_reg;
         status_code_reg <= tx_ack_valid ? tx_ack_code : status_code_reg;
      end
   end

   // Checks
   sequence s_esc_ready;
      esc_reg == ES_C3 && guard_met && !rx_take;
   endsequence
   property p_spi_api; // [R09]
      @(posedge ref_clk) disable iff (!rst_b) spi_port_sel |=> api_mode_reg && !api_escaped_reg;
   endproperty
   a_spi_api: assert property (p_spi_api) else $error("SPI port not in unescaped frame mode");
   property p_mode_load; // [R02]
      @(posedge ref_clk) disable iff (!rst_b)
         mode_load && !spi_port_sel && serial_mode_select == MODE_TRANSPARENT |=> !api_mode_reg;
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("Mode select not applied");
   property p_queue; // [R03]
      @(posedge ref_clk) disable iff (!rst_b)
         rx_take && !api_mode_reg && esc_reg != ES_CMD |=> cnt_reg == $past(cnt_reg) + 1'b1;
   endproperty
   a_queue: assert property (p_queue) else $error("Serial byte not queued");
   property p_full; // [R08]
      @(posedge ref_clk) disable iff (!rst_b)
         fl_reg == FL_FILL && !rx_take && esc_reg == ES_IDLE && !api_mode_reg && cnt_reg >= limit
         |=> fl_reg == FL_SEND ##1 pkt_valid_reg;
   endproperty
   a_full: assert property (p_full) else $error("Full buffer not sent");
   property p_zero_to; // [R06]
      @(posedge ref_clk) disable iff (!rst_b)
         fl_reg == FL_FILL && !rx_take && esc_reg == ES_IDLE && !api_mode_reg && cnt_reg != '0
         && packetization_timeout == 8'h00 |=> fl_reg == FL_SEND;
   endproperty
   a_zero_to: assert property (p_zero_to) else $error("Zero timeout did not send");
   property p_escape; // [R17]
      @(posedge ref_clk) disable iff (!rst_b)
         s_esc_ready |=> cmd_mode_reg && cnt_reg == $past(mark_reg);
   endproperty
   a_escape: assert property (p_escape) else $error("Escape characters kept in buffer");
   property p_cmd_hold; // [R12]
      @(posedge ref_clk) disable iff (!rst_b)
         cmd_mode_reg && ser_rx_valid && fl_reg == FL_FILL |=> cnt_reg <= $past(cnt_reg);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("Command byte queued for radio");
   property p_io; // [R11]
      @(posedge ref_clk) disable iff (!rst_b) io_sample_fwd_reg |-> $past(api_mode_reg);
   endproperty
   a_io: assert property (p_io) else $error("I/O sample sent outside frame mode");
   property p_ack; // [R14]
      @(posedge ref_clk) disable iff (!rst_b)
         tx_ack_valid && api_mode_reg |=> status_frame_valid_reg && status_code_reg == $past(tx_ack_code);
   endproperty
   a_ack: assert property (p_ack) else $error("Acknowledgment not reported");
   property p_fwd; // [R04]
      @(posedge ref_clk) disable iff (!rst_b) rf_take |=> ser_tx_valid_reg;
   endproperty
   a_fwd: assert property (p_fwd) else $error("Radio byte not presented");
endmodule : smp_packetizer
`default_nettype wire

/* File: tb/smp_partner.sv */
// Far-side model: radio packet sink and serial output sink, both stalling
`timescale 1ns/10ps
`default_nettype none
module smp_partner
   import smp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic pkt_valid_reg,
   input wire logic [7:0] pkt_data_reg,
   input wire logic pkt_last_reg,
   output logic pkt_ready,
   input wire logic ser_tx_valid_reg,
   input wire logic [7:0] ser_tx_data_reg,
   input wire logic [SRC_W-1:0] ser_tx_src_reg,
   output logic ser_tx_ready
);
   logic [2:0] cnt = 3'h0;
   logic [8:0] pq[$];
   logic [23:0] sq[$];
   // Stall on a fixed pattern so both buffers must hold words
   always @(posedge ref_clk) begin
      if (pkt_valid_reg === 1'b1 && pkt_ready === 1'b1) begin
         pq.push_back({pkt_last_reg, pkt_data_reg});
      end
      if (ser_tx_valid_reg === 1'b1 && ser_tx_ready === 1'b1) begin
         sq.push_back({ser_tx_src_reg, ser_tx_data_reg});
      end
      cnt <= cnt + 3'h1;
      pkt_ready <= #5 rst_b && (cnt[1:0] != 2'h2);
      ser_tx_ready <= #5 rst_b && (cnt < 3'h5);
   end
endmodule : smp_partner
`default_nettype wire

/* File: tb/test_smp_packetizer.sv */
// Self-checking testbench of the serial mode packetizer
`timescale 1ns/10ps
`default_nettype none
module test_smp_packetizer
   import smp_pkg::*;
;
   localparam int GUARD = 50;
   logic ref_clk, rst_b, mode_load, spi_port_sel, cmd_exit, ser_rx_valid, ser_rx_ready_reg;
   logic [1:0] serial_mode_select;
   logic [7:0] packetization_timeout, escape_character, ser_rx_data, local_byte_reg;
   logic [6:0] max_payload_bytes;
   logic local_byte_valid_reg, pkt_valid_reg, pkt_last_reg, pkt_ready, radio_rx_valid;
   logic [7:0] pkt_data_reg, radio_rx_data, ser_tx_data_reg, tx_ack_code, status_code_reg;
   logic [SRC_W-1:0] radio_rx_src, ser_tx_src_reg;
   logic radio_rx_ready_reg, ser_tx_valid_reg, ser_tx_ready, io_sample_valid, io_sample_fwd_reg;
   logic tx_ack_valid, status_frame_valid_reg, api_mode_reg, api_escaped_reg, cmd_mode_reg;
   int n_fail, n_checks, cyc, n_loc, n_io, n_st, i;
   smp_packetizer #(.GUARD_SILENCE_CYCLES(GUARD), .TIMEOUT_CYCLES_PER_UNIT(4),
      .PAYLOAD_MAX(MAX_PAYLOAD)) u_smp_packetizer (.ref_clk(ref_clk), .rst_b(rst_b),
      .mode_load(mode_load), .serial_mode_select(serial_mode_select),
      .spi_port_sel(spi_port_sel), .packetization_timeout(packetization_timeout),
      .escape_character(escape_character), .max_payload_bytes(max_payload_bytes),
      .cmd_exit(cmd_exit), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
      .ser_rx_ready_reg(ser_rx_ready_reg), .local_byte_valid_reg(local_byte_valid_reg),
      .local_byte_reg(local_byte_reg), .pkt_valid_reg(pkt_valid_reg),
      .pkt_data_reg(pkt_data_reg), .pkt_last_reg(pkt_last_reg), .pkt_ready(pkt_ready),
      .radio_rx_valid(radio_rx_valid), .radio_rx_data(radio_rx_data),
      .radio_rx_src(radio_rx_src), .radio_rx_ready_reg(radio_rx_ready_reg),
      .ser_tx_valid_reg(ser_tx_valid_reg), .ser_tx_data_reg(ser_tx_data_reg),
      .ser_tx_src_reg(ser_tx_src_reg), .ser_tx_ready(ser_tx_ready),
      .io_sample_valid(io_sample_valid), .io_sample_fwd_reg(io_sample_fwd_reg),
      .tx_ack_valid(tx_ack_valid), .tx_ack_code(tx_ack_code),
      .status_frame_valid_reg(status_frame_valid_reg), .status_code_reg(status_code_reg),
      .api_mode_reg(api_mode_reg), .api_escaped_reg(api_escaped_reg),
      .cmd_mode_reg(cmd_mode_reg));
   smp_partner u_smp_partner (.ref_clk(ref_clk), .rst_b(rst_b), .pkt_valid_reg(pkt_valid_reg),
      .pkt_data_reg(pkt_data_reg), .pkt_last_reg(pkt_last_reg), .pkt_ready(pkt_ready),
      .ser_tx_valid_reg(ser_tx_valid_reg), .ser_tx_data_reg(ser_tx_data_reg),
      .ser_tx_src_reg(ser_tx_src_reg), .ser_tx_ready(ser_tx_ready));
   always #25 ref_clk = ~ref_clk;
   task automatic stop_test();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (exp !== got) begin
         n_fail++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask : tick
   task automatic host_send(input logic [7:0] b);
      int k;
      ser_rx_valid = 1'b1;
      ser_rx_data = b;
      for (k = 0; k < 500 && ser_rx_ready_reg !== 1'b1; k++) tick(1);
      tick(1);
      ser_rx_valid = 1'b0;
      tick(1);
   endtask : host_send
   task automatic radio_send(input logic [7:0] b, input logic [SRC_W-1:0] s);
      int k;
      radio_rx_valid = 1'b1;
      radio_rx_data = b;
      radio_rx_src = s;
      for (k = 0; k < 500 && radio_rx_ready_reg !== 1'b1; k++) tick(1);
      tick(1);
      radio_rx_valid = 1'b0;
      tick(1);
   endtask : radio_send
   // Whole packet of n bytes counting up from base, last flag on the final one
   task automatic expect_pkt(input int n, input logic [7:0] base);
      int k;
      for (k = 0; k < 400 && u_smp_partner.pq.size() < n; k++) tick(1);
      tick(4);
      chk(24'(n), 24'(u_smp_partner.pq.size()));
      for (k = 0; k < n && k < u_smp_partner.pq.size(); k++) begin
         chk({15'h0000, k == n - 1, base + 8'(k)}, 24'(u_smp_partner.pq[k]));
      end
      u_smp_partner.pq.delete();
   endtask : expect_pkt
   task automatic expect_tx(input logic [7:0] b, input logic [SRC_W-1:0] s);
      int k;
      for (k = 0; k < 100 && u_smp_partner.sq.size() == 0; k++) tick(1);
      chk({s, b}, (u_smp_partner.sq.size() > 0) ? u_smp_partner.sq.pop_front() : 24'hFFFFFF);
   endtask : expect_tx
   task automatic load_mode(input logic [1:0] m);
      serial_mode_select = m;
      mode_load = 1'b1;
      tick(1);
      mode_load = 1'b0;
      tick(2);
   endtask : load_mode
   always @(posedge ref_clk) begin
      cyc++;
      n_loc += (local_byte_valid_reg === 1'b1);
      n_io += (io_sample_fwd_reg === 1'b1);
      n_st += (status_frame_valid_reg === 1'b1);
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      {ref_clk, rst_b, mode_load, spi_port_sel, cmd_exit, ser_rx_valid, radio_rx_valid} = 7'h00;
      {io_sample_valid, tx_ack_valid, serial_mode_select, ser_rx_data, radio_rx_data} = 20'h00000;
      packetization_timeout = 8'h00;
      escape_character = ESC_CHAR_DEFAULT;
      max_payload_bytes = 7'h00;
      radio_rx_src = 16'h0000;
      tx_ack_code = 8'h00;
      tick(5);
      rst_b = 1'b1;
      tick(2);
      chk({api_mode_reg, cmd_mode_reg}, 24'h0);
      host_send(8'hA0);
      expect_pkt(1, 8'hA0);
      packetization_timeout = 8'h02;
      for (i = 0; i < 3; i++) host_send(8'hB0 + 8'(i));
      tick(3);
      chk(24'h0, 24'(u_smp_partner.pq.size()));
      expect_pkt(3, 8'hB0);
      // Long timeout so only the size limit can end this packet
      packetization_timeout = 8'hFF;
      max_payload_bytes = 7'h04;
      for (i = 0; i < 4; i++) host_send(8'hC0 + 8'(i));
      expect_pkt(4, 8'hC0);
      max_payload_bytes = 7'h00;
      host_send(8'h11);
      tick(GUARD + 10);
      for (i = 0; i < ESC_COUNT; i++) host_send(ESC_CHAR_DEFAULT);
      tick(GUARD + 10);
      expect_pkt(1, 8'h11);
      chk(24'(cmd_mode_reg), 24'h1);
      host_send(8'h55);
      tick(10);
      chk(24'(n_loc), 24'h1);
      chk(24'(local_byte_reg), 24'h55);
      chk(24'(u_smp_partner.pq.size()), 24'h0);
      cmd_exit = 1'b1;
      tick(1);
      cmd_exit = 1'b0;
      tick(2);
      chk(24'(cmd_mode_reg), 24'h0);
      for (i = 0; i < 3; i++) radio_send(8'hD0 + 8'(i), 16'h1234);
      for (i = 0; i < 3; i++) expect_tx(8'hD0 + 8'(i), 16'h0000);
      io_sample_valid = 1'b1;
      tick(1);
      io_sample_valid = 1'b0;
      tick(3);
      chk(24'(n_io), 24'h0);
      load_mode(MODE_API);
      chk(24'({api_mode_reg, api_escaped_reg}), 24'h2);
      host_send(8'h77);
      tick(2);
      chk({8'(n_loc), 8'(u_smp_partner.pq.size()), local_byte_reg}, 24'h020077);
      io_sample_valid = 1'b1;
      tx_ack_valid = 1'b1;
      tx_ack_code = 8'h21;
      tick(1);
      {io_sample_valid, tx_ack_valid} = 2'h0;
      tick(3);
      chk(24'(n_io), 24'h1);
      chk({8'(n_st), 8'h00, status_code_reg}, 24'h010021);
      radio_send(8'hE0, 16'h1234);
      expect_tx(8'hE0, 16'h1234);
      load_mode(MODE_API_ESC);
      chk(24'({api_mode_reg, api_escaped_reg}), 24'h3);
      spi_port_sel = 1'b1;
      tick(2);
      chk(24'({api_mode_reg, api_escaped_reg}), 24'h2);
      load_mode(MODE_TRANSPARENT);
      chk(24'({api_mode_reg, api_escaped_reg}), 24'h2);
      spi_port_sel = 1'b0;
      tick(2);
      chk(24'({api_mode_reg, api_escaped_reg}), 24'h0);
      stop_test();
   end
endmodule : test_smp_packetizer
`default_nettype wire
